// File: logic/bfd_pkg.sv
package bfd_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] BFD_OFS_STRING_FAULT_FLAGS = 8'h12;
  localparam logic [7:0] BFD_OFS_SEQUENCER_STATE_VIEW = 8'h14;
  localparam logic [7:0] BFD_OFS_MEASURED_DIMMING_DUTY = 8'h16;
  localparam logic [7:0] BFD_OFS_APPLIED_DIMMING_DUTY = 8'h18;
  localparam logic [7:0] BFD_OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] BFD_OFS_IRQ_MASK = 8'h22;
  // Field positions in string_fault_flags
  localparam int BFD_BIT_BUS_TIMEOUT_FLAG = 14;
  localparam int BFD_BIT_BUS_TIMEOUT_ACK = 13;
  localparam int BFD_BIT_BAD_STRING_CFG_FLAG = 12;
  localparam int BFD_BIT_BAD_STRING_CFG_ACK = 11;
  localparam int BFD_BIT_COMBINED_FLAG = 10;
  localparam int BFD_BIT_COMBINED_ACK = 9;
  localparam int BFD_BIT_GROUNDED = 8;
  localparam int BFD_BIT_SHORTED = 7;
  localparam int BFD_BIT_OPEN = 6;
  localparam int BFD_BIT_CHANNEL_LSB = 0;
  localparam int BFD_STATE_WIDTH = 5;
  localparam int BFD_NUM_EVENTS = 3;
  // Reset values
  localparam logic [15:0] BFD_RST_REG = 16'h0000;
  localparam logic [2:0] BFD_RST_EVENTS = 3'h0;
  // Sequencer state codes
  localparam logic [4:0] BFD_SEQ_DISABLED = 5'h00;
  localparam logic [4:0] BFD_SEQ_REGULATOR_POWERUP = 5'h01;
  localparam logic [4:0] BFD_SEQ_FUSE_LOAD = 5'h02;
  localparam logic [4:0] BFD_SEQ_STANDBY = 5'h03;
  localparam logic [4:0] BFD_SEQ_CONVERTER_RAMPUP_FIRST = 5'h04;
  localparam logic [4:0] BFD_SEQ_CONVERTER_RAMPUP_LAST = 5'h0f;
  localparam logic [4:0] BFD_SEQ_NORMAL = 5'h10;
  localparam logic [4:0] BFD_SEQ_SHUTDOWN = 5'h11;
  localparam logic [4:0] BFD_SEQ_FAULT_RETRY = 5'h12;
  localparam logic [4:0] BFD_SEQ_EVERY_STRING_FAILED = 5'h13;
endpackage : bfd_pkg

// File: logic/bfd_regs.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module bfd_regs
  import bfd_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int CHANNELS = 4
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [ADDR_WIDTH-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic bus_timeout_fault_i,
  input wire logic bad_string_cfg_fault_i,
  input wire logic grounded_string_i,
  input wire logic shorted_string_fault_i,
  input wire logic open_string_fault_i,
  input wire logic [CHANNELS-1:0] channel_fault_i,
  input wire logic [BFD_STATE_WIDTH-1:0] sequencer_state_i,
  input wire logic [15:0] measured_duty_i,
  input wire logic [15:0] applied_duty_i,
  output logic [15:0] reg_rdata_o,
  output logic fault_pin_o,
  output logic irq_o
);

  // Sizes the logic refuses: the flag word is laid out for exactly four channels in bits 3:0,
  // and the port takes at least eight address bits, though the offsets fit in six
  if (CHANNELS != 4)
  begin : g_bad_channels
    $error("bfd_regs: CHANNELS must be 4");
  end
  if (ADDR_WIDTH < 8)
  begin : g_bad_addr
    $error("bfd_regs: ADDR_WIDTH must be at least 8");
  end

  // How the group behaves, in brief:
  // - three latched faults (bus timeout, bad string set-up, combined string fault)
  //   each sit beside an ack bit; a write clears a fault only when it carries both
  // - a write with just one of the pair does nothing, so a stray read-modify-write
  //   that copies a set flag back without its ack cannot clear it by accident
  // - a fault input still high in the clear cycle keeps its flag set; the source
  //   wins so that a persisting fault is never lost
  // - shorted and open detail bits latch like the combined flag and drop only on its clear write
  // - the grounded bit, channel bits, sequencer code and both duties are live views,
  //   sampled once, so a read shows the input as it stood one cycle earlier
  // - fault_pin_o is the OR of the three latched faults and ignores the mask
  // - irq_o comes from a sticky status word set on each rising flag edge, gated by
  //   a mask; a status read clears it, but an edge in that same cycle survives
  // - every register, live views included, resets to zero

  // Latched fault flags and their detail bits
  logic bus_timeout_flag;
  logic bad_string_cfg_flag;
  logic combined_string_fault_flag;
  logic shorted_string_flag;
  logic open_string_flag;
  // Live views, sampled once
  logic [CHANNELS-1:0] channel_fault;
  logic grounded_string_flag;
  logic [BFD_STATE_WIDTH-1:0] sequencer_state;
  logic [15:0] measured_duty;
  logic [15:0] applied_duty;
  // Interrupt state and read data
  logic [BFD_NUM_EVENTS-1:0] irq_status;
  logic [BFD_NUM_EVENTS-1:0] irq_mask;
  logic [15:0] rdata;

  // Next values, one per register
  logic next_bus_timeout_flag;
  logic next_bad_string_cfg_flag;
  logic next_combined_string_fault_flag;
  logic next_shorted_string_flag;
  logic next_open_string_flag;
  logic [CHANNELS-1:0] next_channel_fault;
  logic next_grounded_string_flag;
  logic [BFD_STATE_WIDTH-1:0] next_sequencer_state;
  logic [15:0] next_measured_duty;
  logic [15:0] next_applied_duty;
  logic [BFD_NUM_EVENTS-1:0] next_irq_status;
  logic [BFD_NUM_EVENTS-1:0] next_irq_mask;
  logic [15:0] next_rdata;

  // Decoded strobes and edge detection
  logic flags_write;
  logic clr_timeout;
  logic clr_bad_cfg;
  logic clr_combined;
  logic any_string_fault;
  logic [BFD_NUM_EVENTS-1:0] events;
  logic irq_mask_write;
  logic irq_status_read;
  // Offsets at the port's address width
  logic [ADDR_WIDTH-1:0] ofs_flags;
  logic [ADDR_WIDTH-1:0] ofs_state;
  logic [ADDR_WIDTH-1:0] ofs_meas;
  logic [ADDR_WIDTH-1:0] ofs_appl;
  logic [ADDR_WIDTH-1:0] ofs_irq_st;
  logic [ADDR_WIDTH-1:0] ofs_irq_mk;

  // Offsets widened once to the address width
  assign ofs_flags = ADDR_WIDTH'(BFD_OFS_STRING_FAULT_FLAGS);
  assign ofs_state = ADDR_WIDTH'(BFD_OFS_SEQUENCER_STATE_VIEW);
  assign ofs_meas = ADDR_WIDTH'(BFD_OFS_MEASURED_DIMMING_DUTY);
  assign ofs_appl = ADDR_WIDTH'(BFD_OFS_APPLIED_DIMMING_DUTY);
  assign ofs_irq_st = ADDR_WIDTH'(BFD_OFS_IRQ_STATUS);
  assign ofs_irq_mk = ADDR_WIDTH'(BFD_OFS_IRQ_MASK);

  // Clear needs the flag bit and its ack bit in one write
  assign flags_write = reg_write_i && (reg_addr_i == ofs_flags);
  assign clr_timeout = flags_write && reg_wdata_i[BFD_BIT_BUS_TIMEOUT_FLAG]
                       && reg_wdata_i[BFD_BIT_BUS_TIMEOUT_ACK];
  assign clr_bad_cfg = flags_write && reg_wdata_i[BFD_BIT_BAD_STRING_CFG_FLAG]
                       && reg_wdata_i[BFD_BIT_BAD_STRING_CFG_ACK];
  assign clr_combined = flags_write && reg_wdata_i[BFD_BIT_COMBINED_FLAG]
                        && reg_wdata_i[BFD_BIT_COMBINED_ACK];
  assign any_string_fault = open_string_fault_i || shorted_string_fault_i || grounded_string_i;
  // Rising edges of the latched flags feed the sticky interrupt status
  assign events = {next_combined_string_fault_flag && !combined_string_fault_flag,
                   next_bad_string_cfg_flag && !bad_string_cfg_flag,
                   next_bus_timeout_flag && !bus_timeout_flag};

  // Bus timeout latch; a fault present in the clear cycle wins over the clear,
  // since dropping a fault that is still there would hide it from the host
  always_comb
  begin
    next_bus_timeout_flag = bus_timeout_fault_i || (bus_timeout_flag && !clr_timeout);
  end

  // Bus timeout register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bus_timeout_flag <= 1'b0;
    end
    else
    begin
      bus_timeout_flag <= next_bus_timeout_flag;
    end
  end

  // Bad string set-up latch; same priority of fault over clear
  always_comb
  begin
    next_bad_string_cfg_flag = bad_string_cfg_fault_i || (bad_string_cfg_flag && !clr_bad_cfg);
  end

  // Bad string set-up register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      bad_string_cfg_flag <= 1'b0;
    end
    else
    begin
      bad_string_cfg_flag <= next_bad_string_cfg_flag;
    end
  end

  // Combined string fault and its detail bits; the details share one clear,
  // so software can read which kind of fault it was until it acks the summary
  always_comb
  begin
    next_combined_string_fault_flag = any_string_fault
                                      || (combined_string_fault_flag && !clr_combined);
    next_shorted_string_flag = shorted_string_fault_i || (shorted_string_flag && !clr_combined);
    next_open_string_flag = open_string_fault_i || (open_string_flag && !clr_combined);
  end

  // Combined string fault registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      combined_string_fault_flag <= 1'b0;
      shorted_string_flag <= 1'b0;
      open_string_flag <= 1'b0;
    end
    else
    begin
      combined_string_fault_flag <= next_combined_string_fault_flag;
      shorted_string_flag <= next_shorted_string_flag;
      open_string_flag <= next_open_string_flag;
    end
  end

  // Live views; one sampling stage, so reads lag the inputs by a cycle
  always_comb
  begin
    next_grounded_string_flag = grounded_string_i;
    next_channel_fault = channel_fault_i;
    next_sequencer_state = sequencer_state_i;
    next_measured_duty = measured_duty_i;
    next_applied_duty = applied_duty_i;
  end

  // Live view registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      grounded_string_flag <= 1'b0;
      channel_fault <= '0;
      sequencer_state <= '0;
      measured_duty <= BFD_RST_REG;
      applied_duty <= BFD_RST_REG;
    end
    else
    begin
      grounded_string_flag <= next_grounded_string_flag;
      channel_fault <= next_channel_fault;
      sequencer_state <= next_sequencer_state;
      measured_duty <= next_measured_duty;
      applied_duty <= next_applied_duty;
    end
  end

  // Interrupt register strobes
  assign irq_mask_write = reg_write_i && (reg_addr_i == ofs_irq_mk);
  assign irq_status_read = reg_read_i && (reg_addr_i == ofs_irq_st);

  // Interrupt mask; plain read/write, only the low event bits are kept
  always_comb
  begin
    next_irq_mask = irq_mask;
    if (irq_mask_write)
      next_irq_mask = reg_wdata_i[BFD_NUM_EVENTS-1:0];
  end

  // Interrupt mask register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      irq_mask <= BFD_RST_EVENTS;
    end
    else
    begin
      irq_mask <= next_irq_mask;
    end
  end

  // Interrupt status; a read clears it, but an event in the same cycle wins,
  // otherwise a fault arriving under the read would never raise the line
  always_comb
  begin
    next_irq_status = irq_status;
    if (irq_status_read)
      next_irq_status = BFD_RST_EVENTS;
    next_irq_status = next_irq_status | events;
  end

  // Interrupt status register
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      irq_status <= BFD_RST_EVENTS;
    end
    else
    begin
      irq_status <= next_irq_status;
    end
  end

  // Read mux; reserved and unmapped bits read as zero
  always_comb
  begin
    next_rdata = BFD_RST_REG;
    if (reg_read_i)
    begin
      case (reg_addr_i)
        ofs_flags:
        begin
          next_rdata[BFD_BIT_BUS_TIMEOUT_FLAG] = bus_timeout_flag;
          next_rdata[BFD_BIT_BAD_STRING_CFG_FLAG] = bad_string_cfg_flag;
          next_rdata[BFD_BIT_COMBINED_FLAG] = combined_string_fault_flag;
          next_rdata[BFD_BIT_GROUNDED] = grounded_string_flag;
          next_rdata[BFD_BIT_SHORTED] = shorted_string_flag;
          next_rdata[BFD_BIT_OPEN] = open_string_flag;
          next_rdata[BFD_BIT_CHANNEL_LSB +: CHANNELS] = channel_fault;
        end
        ofs_state: next_rdata[BFD_STATE_WIDTH-1:0] = sequencer_state;
        ofs_meas: next_rdata = measured_duty;
        ofs_appl: next_rdata = applied_duty;
        ofs_irq_st: next_rdata[BFD_NUM_EVENTS-1:0] = irq_status;
        ofs_irq_mk: next_rdata[BFD_NUM_EVENTS-1:0] = irq_mask;
        default: next_rdata = BFD_RST_REG;
      endcase
    end
  end

  // Read data register; zero outside the cycle after a read strobe,
  // so a host that samples late sees zero rather than stale data
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rdata <= BFD_RST_REG;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // Outputs: fault pin follows latched flags, irq gated by mask;
  // both are gates over registered flags only, with no path from the inputs
  assign reg_rdata_o = rdata;
  assign fault_pin_o = bus_timeout_flag || bad_string_cfg_flag || combined_string_fault_flag;
  assign irq_o = |(irq_status & irq_mask);

endmodule : bfd_regs

// File: tb/bfd_regs_props.sv
`timescale 1ns/1ps
// Checks the flag pin and read port against the inputs that drive them
module bfd_regs_props #(
  parameter int ADDR_WIDTH = 8
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [ADDR_WIDTH-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic bus_timeout_fault_i,
  input wire logic bad_string_cfg_fault_i,
  input wire logic grounded_string_i,
  input wire logic shorted_string_fault_i,
  input wire logic open_string_fault_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic fault_pin_o
);
  // A live source blocks a clear, so clear checks need it quiet
  wire logic any_flt = bus_timeout_fault_i | bad_string_cfg_fault_i | grounded_string_i
    | shorted_string_fault_i | open_string_fault_i;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  AST_RD_IDLE: assert property (!reg_read_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
  AST_TO_SET: assert property (bus_timeout_fault_i |=> fault_pin_o)
    else $error("timeout fault did not raise pin");
  AST_CFG_SET: assert property (bad_string_cfg_fault_i |=> fault_pin_o)
    else $error("config fault did not raise pin");
  AST_COMB_SET: assert property ((open_string_fault_i | shorted_string_fault_i | grounded_string_i) |=> fault_pin_o)
    else $error("string fault did not raise pin");
  AST_HOLD: assert property (fault_pin_o && !reg_write_i |=> fault_pin_o)
    else $error("pin dropped without a clear");
  AST_QUIET: assert property (!fault_pin_o && !any_flt |=> !fault_pin_o)
    else $error("pin rose without a fault");
  AST_CLR_ALL: assert property (reg_write_i && reg_addr_i == 8'h12 && reg_wdata_i == 16'h7e00 && !any_flt
    |=> !fault_pin_o)
    else $error("full clear left pin high");
  AST_ACK_ONLY: assert property (fault_pin_o && reg_write_i && (reg_wdata_i & 16'h5400) == 16'h0 |=> fault_pin_o)
    else $error("write without flag bits cleared pin");
  AST_STATE_HI: assert property (reg_read_i && reg_addr_i == 8'h14 |=> reg_rdata_o[15:5] == 11'h0)
    else $error("state view upper bits not zero");
endmodule : bfd_regs_props
bind bfd_regs bfd_regs_props #(.ADDR_WIDTH(ADDR_WIDTH)) i_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .bus_timeout_fault_i(bus_timeout_fault_i), .bad_string_cfg_fault_i(bad_string_cfg_fault_i),
  .grounded_string_i(grounded_string_i), .shorted_string_fault_i(shorted_string_fault_i),
  .open_string_fault_i(open_string_fault_i), .reg_rdata_o(reg_rdata_o), .fault_pin_o(fault_pin_o));

// File: tb/bfd_host.sv
`timescale 1ns/1ps
// Host side of the register port; one access at a time
module bfd_host (
  input wire logic mclk_i,
  input wire logic [15:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial {addr_o, wdata_o, wr_o, rd_o} = '0;
  // Idle write data is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= d & 16'hffcf;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    @(posedge mclk_i);
    d = rdata_i;
  endtask : rd
endmodule : bfd_host

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 0, rst_i = 1, wr, rd, pin, irq;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, rv, din = 0, dout = 0;
  logic [3:0] ch = 0;
  logic [4:0] st = 0, f = 0;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  always #2 mclk_i = ~mclk_i;
  bfd_host i_host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  bfd_regs i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr),
    .reg_read_i(rd), .bus_timeout_fault_i(f[4]), .bad_string_cfg_fault_i(f[3]), .grounded_string_i(f[2]),
    .shorted_string_fault_i(f[1]), .open_string_fault_i(f[0]), .channel_fault_i(ch), .sequencer_state_i(st),
    .measured_duty_i(din), .applied_duty_i(dout), .reg_rdata_o(rdata), .fault_pin_o(pin), .irq_o(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    i_host.rd(a, rv);
    chk(rv, exp);
  endtask : rdc
  task automatic pulse(input int i);
    @(posedge mclk_i);
    f[i] <= 1'b1;
    @(posedge mclk_i);
    f[i] <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask : pulse
  // Latch, refuse a lone ack, then clear with flag and ack together
  task automatic flt(input int i, input logic [15:0] exp, input logic [15:0] ack);
    pulse(i);
    rdc(8'h12, exp);
    chk({15'h0, pin}, 16'h1);
    i_host.wr(8'h12, ack);
    rdc(8'h12, exp);
    i_host.wr(8'h12, (exp & 16'h5400) | ack);
    rdc(8'h12, 16'h0);
    chk({15'h0, pin}, 16'h0);
  endtask : flt
  task automatic t_live;
    f[2] <= 1'b1;
    ch <= 4'ha;
    din <= 16'ha5c3;
    dout <= 16'h3c5a;
    rdc(8'h12, 16'h050a);
    rdc(8'h16, 16'ha5c3);
    rdc(8'h18, 16'h3c5a);
    for (int s = 0; s < 20; s++)
    begin
      st <= 5'(s);
      rdc(8'h14, 16'(s));
    end
    f[2] <= 1'b0;
    i_host.wr(8'h12, 16'h0600);
    rdc(8'h12, 16'h000a);
  endtask : t_live
  // Earlier faults left status sticky: read it clean first, then unmasked
  // events raise the line, a status read drops it; masked stays low
  task automatic t_irq;
    rdc(8'h20, 16'h0007);
    i_host.wr(8'h22, 16'h0007);
    rdc(8'h22, 16'h0007);
    pulse(4);
    chk({15'h0, irq}, 16'h1);
    rdc(8'h20, 16'h0001);
    pulse(0);
    rdc(8'h20, 16'h0004);
    chk({15'h0, irq}, 16'h0);
    i_host.wr(8'h22, 16'h0000);
    pulse(3);
    rdc(8'h20, 16'h0002);
    chk({15'h0, irq | ~pin}, 16'h0);
    i_host.wr(8'h12, 16'h7e00);
    rdc(8'h12, 16'h000a);
    chk({15'h0, pin}, 16'h0);
  endtask : t_irq
  // Every register and both outputs read zero after reset
  task automatic t_rst;
    for (int i = 0; i < 9; i++)
      rdc(8'h12 + 8'(2 * i), 16'h0);
    chk({14'h0, pin, irq}, 16'h0);
  endtask : t_rst
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Hang guard, far above the couple of hundred cycles the run needs
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_rst();
    flt(4, 16'h4000, 16'h2000);
    flt(3, 16'h1000, 16'h0800);
    flt(0, 16'h0440, 16'h0200);
    flt(1, 16'h0480, 16'h0200);
    t_live();
    t_irq();
    summarize();
  end
endmodule : tb_top
